// *** hdl/adt_regs.svh ***
// Purpose: register offsets, field positions, reset values for the dead-time block
// Assumes: 32-bit axi4-lite, one aligned word per register
// Notes: included by bare name
`ifndef ADT_REGS_SVH
`define ADT_REGS_SVH
`define ADT_OFF_CTRL    8'h00
`define ADT_OFF_POS     8'h04
`define ADT_OFF_NEG     8'h08
`define ADT_OFF_PER     8'h0C
`define ADT_OFF_DV1     8'h10
`define ADT_OFF_DV2     8'h14
`define ADT_OFF_DB1     8'h18
`define ADT_OFF_DB2     8'h1C
`define ADT_OFF_STAT    8'h20
`define ADT_OFF_EVT     8'h24
`define ADT_OFF_CNT     8'h28
// control field positions
`define ADT_CTL_EN      0
`define ADT_CTL_SAME    1
`define ADT_CTL_BUF1    2
`define ADT_CTL_BUF2    3
`define ADT_CTL_MODE_LO 4
`define ADT_CTL_MODE_HI 5
`define ADT_CTL_DOWN    6
`define ADT_CTL_RUN     7
// event write bits
`define ADT_EVT_CLEAR   0
// status field positions
`define ADT_ST_ERR      0
`define ADT_ST_PROT     1
`define ADT_ST_HALF     2
`define ADT_ST_DIR      3
`define ADT_PER_RST     16'hFFFF
`define ADT_RESP_OKAY   2'h0
`define ADT_RESP_SLVERR 2'h2
`endif

// *** hdl/adt_pkg.sv ***
// Purpose: shared types for the dead-time compare block
// Assumes: nothing beyond the register header
// Notes: modes are a two-bit field of the control register
`default_nettype none
package adt_pkg;
	typedef enum logic [1:0]
	{
		ADT_MODE_SAW_ONESHOT = 2'h0,
		ADT_MODE_TRI1        = 2'h1,
		ADT_MODE_TRI2        = 2'h2,
		ADT_MODE_TRI3        = 2'h3
	} adt_mode_t;
endpackage : adt_pkg
`default_nettype wire

// *** hdl/adt_calc_if.sv ***
// Purpose: carries calculator inputs and results between block modules
// Assumes: single clock domain
// Notes: pure combinational path
`default_nettype none
interface adt_calc_if #(parameter int W = 16);
	logic [W-1:0] pos;
	logic [W-1:0] per;
	logic [W-1:0] dv1;
	logic [W-1:0] dv2;
	logic         tri_mode;
	logic         down;
	logic         second;
	logic [W-1:0] neg;
	logic [W-1:0] pos_adj;
	logic         err;
	logic         prot;
	modport src (output pos, per, dv1, dv2, tri_mode, down, second,
		input neg, pos_adj, err, prot);
	modport calc (input pos, per, dv1, dv2, tri_mode, down, second,
		output neg, pos_adj, err, prot);
endinterface : adt_calc_if
`default_nettype wire

// *** hdl/adt_calc.sv ***
// Purpose: negative compare value and dead-time error adjustment
// Assumes: dead times already resolved for same-dead-time select
// Notes: combinational; widened arithmetic avoids wrap
`default_nettype none
module adt_calc #(parameter int W = 16)
(
	adt_calc_if.calc c // calculator port
);
	logic [W:0] pos_w;
	logic [W:0] per_w;
	logic [W:0] d1_w;
	logic [W:0] d2_w;
	logic [W:0] dv_w;
	always_comb
	begin
		pos_w = {1'b0, c.pos};
		per_w = {1'b0, c.per};
		d1_w = {1'b0, c.dv1};
		d2_w = {1'b0, c.dv2};
		dv_w = c.second ? d2_w : d1_w;
		c.err = 1'b0;
		c.prot = 1'b0;
		c.pos_adj = c.pos;
		c.neg = c.pos;
		// triangle: protection holds level for pos 0 or pos >= period
		if (c.tri_mode && (pos_w == '0 || pos_w >= per_w))
			c.prot = 1'b1;
		if (c.tri_mode && pos_w >= per_w + dv_w)
		begin
			c.neg = W'(per_w - 1'b1);
			c.err = 1'b1;
		end
		else if (c.tri_mode && !c.second && pos_w <= d1_w)
		begin
			c.err = 1'b1;
			c.pos_adj = W'(d1_w + 1'b1);
			c.neg = W'(1);
		end
		else if ((c.tri_mode || c.down) && c.second && pos_w < d2_w)
		begin
			c.err = 1'b1;
			c.pos_adj = c.dv2;
			c.neg = '0;
		end
		else if (!c.tri_mode && !c.down && !c.second && pos_w < d1_w)
		begin
			c.err = 1'b1;
			c.pos_adj = c.dv1;
			c.neg = '0;
		end
		else if (!c.tri_mode && (c.down != c.second) && pos_w + dv_w > per_w)
		begin
			c.err = 1'b1;
			c.pos_adj = W'(per_w - dv_w);
			c.neg = c.per;
		end
		else if (!c.tri_mode && !c.down && c.second)
			c.neg = W'(pos_w + d2_w);
		else if (!c.tri_mode && c.down && !c.second)
			c.neg = W'(pos_w + d1_w);
		else
			c.neg = W'(pos_w - dv_w);
		// saw one-shot: out-of-order points not corrected further
	end
endmodule : adt_calc
`default_nettype wire

// *** hdl/adt_top.sv ***
// Purpose: automatic dead-time compare logic of one pwm timer channel
// Assumes: axi4-lite slave, one clock, software keeps its own limits
// Notes: the timer counter runs inside this block to make cycle ends
`default_nettype none
`include "adt_regs.svh"
module adt_top
	import adt_pkg::*;
#(
	parameter int W = 16
)
(
	input  wire logic         clk_i,     // 200 mhz clock
	input  wire logic         rst_n_i,   // synchronous reset, low
	input  wire logic [7:0]   awaddr_i,  // write address
	input  wire logic         awvalid_i, // write address valid
	output logic              awready_o, // write address ready
	input  wire logic [31:0]  wdata_i,   // write data
	input  wire logic [3:0]   wstrb_i,   // byte strobes
	input  wire logic         wvalid_i,  // write data valid
	output logic              wready_o,  // write data ready
	output logic [1:0]        bresp_o,   // write response
	output logic              bvalid_o,  // write response valid
	input  wire logic         bready_i,  // write response ready
	input  wire logic [7:0]   araddr_i,  // read address
	input  wire logic         arvalid_i, // read address valid
	output logic              arready_o, // read address ready
	output logic [31:0]       rdata_o,   // read data
	output logic [1:0]        rresp_o,   // read response
	output logic              rvalid_o,  // read valid
	input  wire logic         rready_i,  // read ready
	output logic              pos_out_o, // positive waveform
	output logic              neg_out_o  // negative waveform
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic         aw_got;
		logic         w_got;
		logic [7:0]   aw;
		logic [31:0]  wd;
		logic [3:0]   ws;
		logic         bv;
		logic [1:0]   br;
		logic         rv;
		logic [31:0]  rd;
		logic [1:0]   rr;
		logic [7:0]   ctl;
		logic [W-1:0] pos;
		logic [W-1:0] neg;
		logic [W-1:0] per;
		logic [W-1:0] dv1;
		logic [W-1:0] dv2;
		logic [W-1:0] db1;
		logic [W-1:0] db2;
		logic [W-1:0] cnt;
		logic         dn;
		logic         err;
		logic         prot;
		logic [W-1:0] padj;
		logic         po;
		logic         no;
	} adt_state_t;

	adt_state_t s_q;
	adt_state_t s_d;
	adt_calc_if #(.W(W)) cif ();

	adt_calc #(.W(W)) u_calc (.c(cif));

	logic      en;
	logic      tri_m;
	logic      half2;
	logic      cyc_end;
	adt_mode_t mode;

	////////////////////////////////////////////////////////////////////////
	// calculator feed
	always_comb
	begin
		mode = adt_mode_t'(s_q.ctl[`ADT_CTL_MODE_HI:`ADT_CTL_MODE_LO]);
		en = s_q.ctl[`ADT_CTL_EN];
		tri_m = (mode != ADT_MODE_SAW_ONESHOT);
		// triangle: down-count is second half; saw: past pos is second half
		half2 = tri_m ? s_q.dn : (s_q.cnt >= s_q.pos);
		cif.pos = s_q.pos;
		cif.per = s_q.per;
		cif.dv1 = s_q.dv1;
		cif.dv2 = s_q.ctl[`ADT_CTL_SAME] ? s_q.dv1 : s_q.dv2;
		cif.tri_mode = tri_m;
		cif.down = tri_m ? s_q.dn : s_q.ctl[`ADT_CTL_DOWN];
		cif.second = half2;
	end

	////////////////////////////////////////////////////////////////////////
	// next-state logic: bus slave, counter, buffers, outputs
	always_comb
	begin
		s_d = s_q;
		cyc_end = 1'b0;
		// counter and cycle end detection
		if (s_q.ctl[`ADT_CTL_RUN])
		begin
			if (tri_m)
			begin
				if (!s_q.dn && s_q.cnt >= s_q.per)
				begin
					s_d.dn = 1'b1;
					s_d.cnt = W'(s_q.cnt - 1'b1);
				end
				else if (s_q.dn && s_q.cnt == '0)
				begin
					s_d.dn = 1'b0;
					s_d.cnt = W'(1);
					cyc_end = 1'b1; // trough
				end
				else
					s_d.cnt = s_q.dn ? W'(s_q.cnt - 1'b1) : W'(s_q.cnt + 1'b1);
			end
			else if (!s_q.ctl[`ADT_CTL_DOWN])
			begin
				cyc_end = (s_q.cnt >= s_q.per); // overflow
				s_d.cnt = cyc_end ? '0 : W'(s_q.cnt + 1'b1);
			end
			else
			begin
				cyc_end = (s_q.cnt == '0); // underflow
				s_d.cnt = cyc_end ? s_q.per : W'(s_q.cnt - 1'b1);
			end
		end
		if (cyc_end && s_q.ctl[`ADT_CTL_BUF1])
			s_d.dv1 = s_q.db1;
		if (cyc_end && s_q.ctl[`ADT_CTL_BUF2])
			s_d.dv2 = s_q.db2;
		// registered one count clock after any input changes
		if (en)
		begin
			s_d.neg = cif.neg;
			s_d.err = cif.err;
			s_d.padj = cif.err ? cif.pos_adj : s_q.pos;
			s_d.prot = cif.prot;
		end
		else
		begin
			s_d.err = 1'b0;
			s_d.prot = 1'b0;
			s_d.padj = s_q.pos;
		end
		// outputs; protection freezes levels in triangle modes
		if (!s_q.prot)
		begin
			s_d.po = (s_q.cnt >= s_q.padj);
			s_d.no = en ? (s_q.cnt < s_q.neg) : !(s_q.cnt >= s_q.padj);
		end
		// write channel: address and data in either order
		if (awvalid_i && !s_q.aw_got && !s_q.bv)
		begin
			s_d.aw_got = 1'b1;
			s_d.aw = awaddr_i;
		end
		if (wvalid_i && !s_q.w_got && !s_q.bv)
		begin
			s_d.w_got = 1'b1;
			s_d.wd = wdata_i;
			s_d.ws = wstrb_i;
		end
		if (s_q.aw_got && s_q.w_got)
		begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bv = 1'b1;
			s_d.br = `ADT_RESP_OKAY;
			case (s_q.aw)
				`ADT_OFF_CTRL: if (s_q.ws[0]) s_d.ctl = s_q.wd[7:0];
				`ADT_OFF_POS:  s_d.pos = W'(s_q.wd);
				// ignored while enabled: software is barred from it
				`ADT_OFF_NEG:  if (!en) s_d.neg = W'(s_q.wd);
				`ADT_OFF_PER:  s_d.per = W'(s_q.wd);
				`ADT_OFF_DV1:  s_d.dv1 = W'(s_q.wd);
				`ADT_OFF_DV2:  s_d.dv2 = W'(s_q.wd);
				`ADT_OFF_DB1:  s_d.db1 = W'(s_q.wd);
				`ADT_OFF_DB2:  s_d.db2 = W'(s_q.wd);
				`ADT_OFF_EVT:
				begin
					if (s_q.wd[`ADT_EVT_CLEAR])
					begin
						s_d.cnt = '0; // clear
						s_d.dn = 1'b0;
						if (s_q.ctl[`ADT_CTL_BUF1]) s_d.dv1 = s_q.db1;
						if (s_q.ctl[`ADT_CTL_BUF2]) s_d.dv2 = s_q.db2;
					end
				end
				`ADT_OFF_STAT, `ADT_OFF_CNT: s_d.br = `ADT_RESP_OKAY;
				default: s_d.br = `ADT_RESP_SLVERR;
			endcase
		end
		if (s_q.bv && bready_i)
			s_d.bv = 1'b0;
		// read channel
		if (arvalid_i && !s_q.rv)
		begin
			s_d.rv = 1'b1;
			s_d.rr = `ADT_RESP_OKAY;
			s_d.rd = '0;
			case (araddr_i)
				`ADT_OFF_CTRL: s_d.rd = 32'(s_q.ctl);
				`ADT_OFF_POS:  s_d.rd = 32'(s_q.pos);
				`ADT_OFF_NEG:  s_d.rd = 32'(s_q.neg);
				`ADT_OFF_PER:  s_d.rd = 32'(s_q.per);
				`ADT_OFF_DV1:  s_d.rd = 32'(s_q.dv1);
				`ADT_OFF_DV2:  s_d.rd = 32'(s_q.dv2);
				`ADT_OFF_DB1:  s_d.rd = 32'(s_q.db1);
				`ADT_OFF_DB2:  s_d.rd = 32'(s_q.db2);
				`ADT_OFF_STAT: s_d.rd = 32'({s_q.dn, half2, s_q.prot, s_q.err});
				`ADT_OFF_EVT:  s_d.rd = '0;
				`ADT_OFF_CNT:  s_d.rd = 32'(s_q.cnt);
				default:       s_d.rr = `ADT_RESP_SLVERR;
			endcase
		end
		else if (s_q.rv && rready_i)
			s_d.rv = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s_q <= '0;
			s_q.per <= W'(`ADT_PER_RST);
		end
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign awready_o = !s_q.aw_got && !s_q.bv;
	assign wready_o = !s_q.w_got && !s_q.bv;
	assign bvalid_o = s_q.bv;
	assign bresp_o = s_q.br;
	assign arready_o = !s_q.rv;
	assign rvalid_o = s_q.rv;
	assign rdata_o = s_q.rd;
	assign rresp_o = s_q.rr;
	assign pos_out_o = s_q.po;
	assign neg_out_o = s_q.no;
endmodule : adt_top
`default_nettype wire

// *** testbench/adt_top_assertions.sv ***
// Purpose: port checks of the dead-time block register bus
// Assumes: one clock, synchronous active-low reset
// Notes: bound to adt_top after the module
`default_nettype none
module adt_top_assertions
(
	input wire logic        clk_i,     // clock
	input wire logic        rst_n_i,   // reset, low
	input wire logic        awvalid_i, // aw valid
	input wire logic        awready_o, // aw ready
	input wire logic        wvalid_i,  // w valid
	input wire logic        wready_o,  // w ready
	input wire logic [1:0]  bresp_o,   // b code
	input wire logic        bvalid_o,  // b valid
	input wire logic        bready_i,  // b ready
	input wire logic        arvalid_i, // ar valid
	input wire logic        arready_o, // ar ready
	input wire logic [31:0] rdata_o,   // read data
	input wire logic [1:0]  rresp_o,   // r code
	input wire logic        rvalid_o,  // r valid
	input wire logic        rready_i   // r ready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////////////
	// both write halves taken on one edge
	sequence s_wr_both;
		awvalid_i && awready_o && wvalid_i && wready_o;
	endsequence
	// an answer waiting for the master
	sequence s_rd_wait;
		rvalid_o && !rready_i;
	endsequence
	// capture edge, then the edge that raises the response
	chk_b_after_wr: assert property (s_wr_both |-> ##2 bvalid_o)
		else $error("no write response after capture");
	chk_b_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
		else $error("write response dropped early");
	chk_b_clear: assert property (bvalid_o && bready_i |=> !bvalid_o)
		else $error("write response not cleared");
	chk_aw_busy: assert property (bvalid_o |-> !awready_o && !wready_o)
		else $error("write channel open while response pends");
	chk_r_after_ar: assert property (arvalid_i && arready_o |=> rvalid_o)
		else $error("no read answer after address");
	chk_r_hold: assert property (s_rd_wait |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o))
		else $error("read answer changed while waiting");
	chk_r_clear: assert property (rvalid_o && rready_i |=> !rvalid_o)
		else $error("read answer not cleared");
	chk_rd_upper: assert property (rvalid_o |-> rdata_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");
endmodule : adt_top_assertions
bind adt_top adt_top_assertions u_chk (.*);
`default_nettype wire

// *** testbench/adt_top_tb.sv ***
// Purpose: self-checking bench for the dead-time compare block
// Assumes: counter stays stopped for the compare rows, so the half follows the positive value in saw rows and stays first in triangle rows
// Notes: period 100, first-half dead time 10, second-half 5 for the compare rows
`default_nettype none
`include "adt_regs.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_mismatch++; \
	$display("wrong value %s expected %h seen %h", nm, e, s); end end
module adt_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] c; logic [15:0] p; logic [15:0] n;} adt_row_t;
	logic        clk_i, rst_n_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
	logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, pos_out_o, neg_out_o;
	logic [7:0]  awaddr_i, araddr_i;
	logic [31:0] wdata_i, rdata_o, rd;
	logic [3:0]  wstrb_i;
	logic [1:0]  bresp_o, rresp_o, rs;
	int          n_mismatch, n_compared, cyc;
	// control, positive value, expected negative value
	adt_row_t    rows [10] = '{
		'{8'h01, 16'h0032, 16'h0028},
		'{8'h01, 16'h0005, 16'h0000},
		'{8'h01, 16'h0000, 16'h0005},
		'{8'h03, 16'h0000, 16'h000A},
		'{8'h41, 16'h0032, 16'h003C},
		'{8'h41, 16'h005F, 16'h0064},
		'{8'h41, 16'h0000, 16'h0000},
		'{8'h11, 16'h0032, 16'h0028},
		'{8'h21, 16'h000A, 16'h0001},
		'{8'h31, 16'h0078, 16'h0063}
	};
	adt_top dut (.*);
	// 5 ns clock
	initial
	begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	// sample at the falling edge so registered answers are settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ha, hw, hb;
		awaddr_i <= a;
		wdata_i <= d;
		awvalid_i <= 1'h1;
		wvalid_i <= 1'h1;
		bready_i <= 1'h1;
		forever
		begin
			@(negedge clk_i);
			ha = awvalid_i && awready_o;
			hw = wvalid_i && wready_o;
			hb = bvalid_o;
			rs = bresp_o;
			@(posedge clk_i);
			if (ha) awvalid_i <= 1'h0;
			if (hw) wvalid_i <= 1'h0;
			if (hb) break;
		end
		bready_i <= 1'h0;
		@(posedge clk_i);
	endtask : wr
	task automatic rdt(input logic [7:0] a);
		bit ha, hr;
		araddr_i <= a;
		arvalid_i <= 1'h1;
		rready_i <= 1'h1;
		forever
		begin
			@(negedge clk_i);
			ha = arvalid_i && arready_o;
			hr = rvalid_o;
			rd = rdata_o;
			rs = rresp_o;
			@(posedge clk_i);
			if (ha) arvalid_i <= 1'h0;
			if (hr) break;
		end
		rready_i <= 1'h0;
		@(posedge clk_i);
	endtask : rdt
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		rdt(a);
		`CHK(nm, e, rd);
	endtask : rchk
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 5'h00;
		awaddr_i = 8'h00;
		araddr_i = 8'h00;
		wdata_i = 32'h00000000;
		wstrb_i = 4'hF;
		rst_n_i = 1'h0;
		repeat (5) @(posedge clk_i);
		// waveform outputs are low while reset is held
		@(negedge clk_i);
		`CHK("positive out in reset", 1'h0, pos_out_o);
		`CHK("negative out in reset", 1'h0, neg_out_o);
		@(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		rchk("period reset", `ADT_OFF_PER, 32'h0000FFFF);
		rchk("control reset", `ADT_OFF_CTRL, 32'h00000000);
		wr(`ADT_OFF_PER, 32'h00000064);
		wr(`ADT_OFF_DV1, 32'h0000000A); // dead times well inside the period
		wr(`ADT_OFF_DV2, 32'h00000005);
		foreach (rows[i])
		begin
			wr(`ADT_OFF_POS, {16'h0000, rows[i].p});
			wr(`ADT_OFF_CTRL, {24'h000000, rows[i].c});
			rchk("negative compare", `ADT_OFF_NEG, {16'h0000, rows[i].n});
			rchk("positive compare", `ADT_OFF_POS, {16'h0000, rows[i].p});
		end
		// last row: positive beyond the period, so error and protection both set
		rchk("status after limit", `ADT_OFF_STAT, 32'h00000003);
		// a software write must not disturb the computed value
		wr(`ADT_OFF_NEG, 32'h00001234);
		`CHK("negative write code", `ADT_RESP_OKAY, rs);
		rchk("negative kept", `ADT_OFF_NEG, 32'h00000063);
		wr(8'h40, 32'h00000001);
		`CHK("unmapped write code", `ADT_RESP_SLVERR, rs);
		rdt(8'h40);
		`CHK("unmapped read code", `ADT_RESP_SLVERR, rs);
		// counter stopped: buffered first-half dead time moves only on a counter clear
		wr(`ADT_OFF_POS, 32'h00000032);
		wr(`ADT_OFF_CTRL, 32'h00000005);
		wr(`ADT_OFF_DB1, 32'h00000014);
		rchk("dead time held", `ADT_OFF_DV1, 32'h0000000A);
		wr(`ADT_OFF_EVT, 32'h00000001);
		rchk("dead time moved", `ADT_OFF_DV1, 32'h00000014);
		rchk("negative after move", `ADT_OFF_NEG, 32'h0000001E);
		// stopped at count 0: positive off, complementary negative on
		@(negedge clk_i);
		`CHK("positive out stopped", 1'h0, pos_out_o);
		`CHK("negative out stopped", 1'h1, neg_out_o);
		@(posedge clk_i);
		// saw up running: second-half buffer moves only at the overflow
		wr(`ADT_OFF_DB2, 32'h00000007);
		wr(`ADT_OFF_CTRL, 32'h0000008D);
		rchk("second dead time held", `ADT_OFF_DV2, 32'h00000005);
		repeat (110) @(posedge clk_i);
		rchk("second dead time moved", `ADT_OFF_DV2, 32'h00000007);
		// triangle running: first-half buffer moves only at the trough
		wr(`ADT_OFF_CTRL, 32'h00000095);
		wr(`ADT_OFF_DB1, 32'h0000000C);
		rchk("first dead time held", `ADT_OFF_DV1, 32'h00000014);
		repeat (210) @(posedge clk_i);
		rchk("first dead time at trough", `ADT_OFF_DV1, 32'h0000000C);
		// second reset in mid-run, with the counter still going
		rst_n_i <= 1'h0;
		@(posedge clk_i);
		@(negedge clk_i);
		`CHK("positive out mid reset", 1'h0, pos_out_o);
		`CHK("negative out mid reset", 1'h0, neg_out_o);
		@(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		rchk("control after reset", `ADT_OFF_CTRL, 32'h00000000);
		results();
	end
	// hang guard, far above the few hundred cycles needed
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			n_mismatch++;
			results();
		end
	end
endmodule : adt_top_tb
`default_nettype wire
